// ### logic/cri_cmp_if.sv
/*
  Carrier between the register block and the mismatch detector.
  Assumes both ends sit on core_clk.
*/
`timescale 1ns/1ns
interface cri_cmp_if;
  logic rawOut;
  logic invert;
  logic ctlAccess;
  logic liveResult;
  logic mismatch;

  modport ctl (output rawOut, output invert, output ctlAccess,
               input liveResult, input mismatch);
  modport det (input rawOut, input invert, input ctlAccess,
               output liveResult, output mismatch);
endinterface

// ### logic/cri_mismatch.sv
/*
  Comparator output polarity and mismatch detector.
  Assumes rawOut is already synchronous to core_clk.
*/
`timescale 1ns/1ns
module cri_mismatch
  import cri_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic arst_n,
  cri_cmp_if.det    cmp
);
  logic resultQ;
  logic copyQ;

  // ---------------------------------------------------------------
  // polarity and sampling
  // ---------------------------------------------------------------
  assign cmp.liveResult = cmp.rawOut ^ cmp.invert; // R18

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultQ <= 1'b0;
    end else begin
      resultQ <= cmp.liveResult;
    end
  end

  // copy taken at the access edge: a change in that same cycle is lost
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      copyQ <= 1'b0;
    end else if (cmp.ctlAccess) begin
      copyQ <= cmp.liveResult; // R20 R15 R17
    end
  end

  assign cmp.mismatch = resultQ != copyQ; // R20

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  access_ends_a: assert property (cmp.ctlAccess |=> !cmp.mismatch) // R15
    else $error("access did not end mismatch");
  change_seen_a: assert property (
    !cmp.ctlAccess && !cmp.mismatch && cmp.liveResult != resultQ
    |=> cmp.mismatch) // R11
    else $error("output change not flagged as mismatch");
  race_cov: cover property (
    cmp.ctlAccess && cmp.liveResult != resultQ); // R17
endmodule

// ### logic/cri_pkg.sv
/*
  Shared constants for the comparator reference and interrupt block:
  register indices and byte addresses, field positions, reset values,
  write masks and mode codes.
  Assumes APB with 32-bit data and one aligned word per register.
*/
// Contract
// R1: thirty-two reference levels: sixteen codes per range, picked by range bit and code.
// R2: low range selects tap equal to code over 24 times supply.
// R3: high range selects tap equal to quarter supply plus code/32 supply.
// R4: internal reference feeds comparator in exactly four of eight modes.
// R5: enabled comparator and reference keep running through sleep.
// R6: mode 111 switches comparator off; clearing bit 7 powers reference down.
// R7: comparator interrupt wakes device while comparator enabled in sleep.
// R8: waking from sleep leaves both control registers unchanged.
// R9: reset loads mode 000, comparator disabled, reference off.
// R10: enable bit 7, range bit 5, code 3-0; bits 6,4 zero.
// R11: flag sets on every output change; output readable at bit 6.
// R12: hardware never clears flag; software write sets or clears it.
// R13: request reaches processor only with comparator, peripheral, global enables set.
// R14: flag still sets when any interrupt enable is clear.
// R15: any comparator control access ends mismatch; access before clearing flag.
// R16: persisting mismatch keeps setting flag, even just after software clear.
// R17: output change during the control access may leave flag unset.
// R18: inversion bit 4 inverts reported output polarity.
// R19: output bit is read-only; writes to it are ignored.
// R20: live output compared with copy latched on every control access.
package cri_pkg;

  // ---------------------------------------------------------------
  // register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_INT_CTL  = 8'h0b;
  localparam logic [7:0]  IDX_IRQ_FLG  = 8'h0c;
  localparam logic [7:0]  IDX_CMP_CTL  = 8'h19;
  localparam logic [7:0]  IDX_PIN_DIR  = 8'h85;
  localparam logic [7:0]  IDX_IRQ_ENA  = 8'h8c;
  localparam logic [7:0]  IDX_VREF_CTL = 8'h99;
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] ADDR_INT_CTL  = {2'b00, IDX_INT_CTL, 2'b00};
  localparam logic [11:0] ADDR_IRQ_FLG  = {2'b00, IDX_IRQ_FLG, 2'b00};
  localparam logic [11:0] ADDR_CMP_CTL  = {2'b00, IDX_CMP_CTL, 2'b00};
  localparam logic [11:0] ADDR_PIN_DIR  = {2'b00, IDX_PIN_DIR, 2'b00};
  localparam logic [11:0] ADDR_IRQ_ENA  = {2'b00, IDX_IRQ_ENA, 2'b00};
  localparam logic [11:0] ADDR_VREF_CTL = {2'b00, IDX_VREF_CTL, 2'b00};

  // ---------------------------------------------------------------
  // reset values and writable bits
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_INT_CTL  = 8'h00;
  localparam logic [7:0] RST_IRQ_FLG  = 8'h00;
  localparam logic [7:0] RST_CMP_CTL  = 8'h00;
  localparam logic [7:0] RST_PIN_DIR  = 8'h3f;
  localparam logic [7:0] RST_IRQ_ENA  = 8'h00;
  localparam logic [7:0] RST_VREF_CTL = 8'h00;
  localparam logic [7:0] MSK_IRQ_FLG  = 8'hc1;
  localparam logic [7:0] MSK_CMP_CTL  = 8'h1f;
  localparam logic [7:0] MSK_PIN_DIR  = 8'h3f;
  localparam logic [7:0] MSK_IRQ_ENA  = 8'hc9;
  localparam logic [7:0] MSK_VREF_CTL = 8'haf;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_GLOBAL_GATE = 7;
  localparam int BIT_PERIPH_GATE = 6;
  localparam int BIT_CMP_FLAG    = 3;
  localparam int BIT_CMP_ENABLE  = 3;
  localparam int BIT_RESULT      = 6;
  localparam int BIT_INVERT      = 4;
  localparam int BIT_INPUT_SW    = 3;
  localparam int BIT_REF_ENABLE  = 7;
  localparam int BIT_REF_RANGE   = 5;

  // ---------------------------------------------------------------
  // modes and ladder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CRI_MODE_RESET = 3'b000,
    CRI_MODE_OFF   = 3'b111
  } cri_mode_t;
  // one bit per mode code: set where the internal reference is routed
  localparam logic [7:0] REF_MODE_MASK   = 8'h78;
  localparam logic [4:0] HIGH_RANGE_BASE = 5'h08;
endpackage

// ### logic/cri_top.sv
/*
  Comparator reference selector, comparator control and change
  interrupt, reached over APB with one aligned word per register.
  Assumes cmpRaw and sleepActive are synchronous to core_clk; the
  analog ladder and comparator sit outside and take the outputs.
*/
`timescale 1ns/1ns
module cri_top
  import cri_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              cmpRaw,
  input  wire logic              sleepActive,
  output      logic              refEnable,
  output      logic              refRangeSelect,
  output      logic [3:0]        refLevelCode,
  output      logic [4:0]        refTapNumer,
  output      logic              refRouted,
  output      logic [2:0]        comparatorModeCode,
  output      logic              inputSwitch,
  output      logic              cmpPowerOn,
  output      logic [5:0]        pinDirection,
  output      logic              irqReq,
  output      logic              wakeReq
);
  logic [7:0]  intCtlQ;
  logic [7:0]  irqFlgQ;
  logic [7:0]  cmpCtlQ;
  logic [7:0]  pinDirQ;
  logic [7:0]  irqEnaQ;
  logic [7:0]  vrefCtlQ;
  logic        comparatorIrqFlagQ;
  logic [31:0] prdataQ;
  logic        preadyQ;
  logic        pslverrQ;
  logic [4:0]  tapNumerQ;
  logic        refRoutedQ;
  logic        cmpOnQ;
  logic        irqReqQ;
  logic        wakeReqQ;
  logic [7:0]  rdByte;
  logic        hit;
  logic        setupDone;
  logic        wrEn;
  logic        cmpOnNow;
  logic        gatesOpen;

  cri_cmp_if cmp ();

  cri_mismatch u_mismatch (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .cmp      (cmp.det)
  );

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // one wait state: pready rises the cycle after the access phase opens
  assign setupDone = psel && penable && !preadyQ;
  assign wrEn      = psel && penable && preadyQ && pwrite && hit;

  always_comb begin
    hit    = 1'b1;
    rdByte = 8'h00;
    if (paddr == ADDR_INT_CTL) begin
      rdByte = intCtlQ;
    end else if (paddr == ADDR_IRQ_FLG) begin
      rdByte = irqFlgQ & MSK_IRQ_FLG;
      rdByte[BIT_CMP_FLAG] = comparatorIrqFlagQ;
    end else if (paddr == ADDR_CMP_CTL) begin
      rdByte = cmpCtlQ & MSK_CMP_CTL;
      rdByte[BIT_RESULT] = cmp.liveResult; // R11
    end else if (paddr == ADDR_PIN_DIR) begin
      rdByte = pinDirQ & MSK_PIN_DIR;
    end else if (paddr == ADDR_IRQ_ENA) begin
      rdByte = irqEnaQ & MSK_IRQ_ENA;
    end else if (paddr == ADDR_VREF_CTL) begin
      rdByte = vrefCtlQ & MSK_VREF_CTL; // R10
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      preadyQ  <= 1'b0;
      pslverrQ <= 1'b0;
      prdataQ  <= 32'h0000_0000;
    end else begin
      preadyQ  <= setupDone;
      pslverrQ <= setupDone && !hit;
      if (setupDone) begin
        prdataQ <= {24'h00_0000, pwrite ? 8'h00 : rdByte};
      end
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // sleep is not an input to these registers, so they persist across it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      intCtlQ  <= RST_INT_CTL;
      irqFlgQ  <= RST_IRQ_FLG;
      cmpCtlQ  <= RST_CMP_CTL; // R9
      pinDirQ  <= RST_PIN_DIR;
      irqEnaQ  <= RST_IRQ_ENA;
      vrefCtlQ <= RST_VREF_CTL; // R9 R10
    end else if (wrEn) begin // R5 R8
      if (paddr == ADDR_INT_CTL) begin
        intCtlQ <= pwdata[7:0];
      end else if (paddr == ADDR_IRQ_FLG) begin
        irqFlgQ <= pwdata[7:0] & MSK_IRQ_FLG;
      end else if (paddr == ADDR_CMP_CTL) begin
        cmpCtlQ <= pwdata[7:0] & MSK_CMP_CTL; // R19
      end else if (paddr == ADDR_PIN_DIR) begin
        pinDirQ <= pwdata[7:0] & MSK_PIN_DIR;
      end else if (paddr == ADDR_IRQ_ENA) begin
        irqEnaQ <= pwdata[7:0] & MSK_IRQ_ENA;
      end else if (paddr == ADDR_VREF_CTL) begin
        vrefCtlQ <= pwdata[7:0] & MSK_VREF_CTL; // R10
      end
    end
  end

  // ---------------------------------------------------------------
  // reference selection and comparator power
  // ---------------------------------------------------------------
  assign cmpOnNow = cmpCtlQ[2:0] != CRI_MODE_RESET &&
                    cmpCtlQ[2:0] != CRI_MODE_OFF; // R6 R9

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tapNumerQ  <= 5'h00;
      refRoutedQ <= 1'b0;
      cmpOnQ     <= 1'b0;
    end else begin
      if (vrefCtlQ[BIT_REF_RANGE]) begin
        tapNumerQ <= {1'b0, vrefCtlQ[3:0]}; // R1 R2
      end else begin
        tapNumerQ <= {1'b0, vrefCtlQ[3:0]} + HIGH_RANGE_BASE; // R1 R3
      end
      refRoutedQ <= REF_MODE_MASK[cmpCtlQ[2:0]]; // R4
      cmpOnQ     <= cmpOnNow;
    end
  end

  // ---------------------------------------------------------------
  // change interrupt
  // ---------------------------------------------------------------
  assign cmp.rawOut    = cmpRaw;
  assign cmp.invert    = cmpCtlQ[BIT_INVERT]; // R18
  assign cmp.ctlAccess = setupDone && paddr == ADDR_CMP_CTL; // R15 R20

  // a mismatch wins over a software clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      comparatorIrqFlagQ <= 1'b0;
    end else if (cmp.mismatch) begin
      comparatorIrqFlagQ <= 1'b1; // R11 R14 R16
    end else if (wrEn && paddr == ADDR_IRQ_FLG) begin
      comparatorIrqFlagQ <= pwdata[BIT_CMP_FLAG]; // R12
    end
  end

  assign gatesOpen = irqEnaQ[BIT_CMP_ENABLE] && intCtlQ[BIT_PERIPH_GATE];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqReqQ  <= 1'b0;
      wakeReqQ <= 1'b0;
    end else begin
      irqReqQ  <= comparatorIrqFlagQ && gatesOpen && cmpOnQ &&
                  intCtlQ[BIT_GLOBAL_GATE]; // R13
      wakeReqQ <= sleepActive && cmpOnQ && comparatorIrqFlagQ &&
                  gatesOpen; // R7
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata             = prdataQ;
  assign pready             = preadyQ;
  assign pslverr            = pslverrQ;
  assign refEnable          = vrefCtlQ[BIT_REF_ENABLE]; // R6
  assign refRangeSelect     = vrefCtlQ[BIT_REF_RANGE];
  assign refLevelCode       = vrefCtlQ[3:0];
  assign refTapNumer        = tapNumerQ;
  assign refRouted          = refRoutedQ;
  assign comparatorModeCode = cmpCtlQ[2:0];
  assign inputSwitch        = cmpCtlQ[BIT_INPUT_SW];
  assign cmpPowerOn         = cmpOnQ;
  assign pinDirection       = pinDirQ[5:0];
  assign irqReq             = irqReqQ;
  assign wakeReq            = wakeReqQ;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  flag_sets_a: assert property (cmp.mismatch |=> comparatorIrqFlagQ) // R11
    else $error("mismatch did not set flag");
  flag_ungated_a: assert property (
    cmp.mismatch && !gatesOpen |=> comparatorIrqFlagQ) // R14
    else $error("flag not set with enables clear");
  clear_wins_a: assert property (
    wrEn && paddr == ADDR_IRQ_FLG && !pwdata[BIT_CMP_FLAG] &&
    !cmp.mismatch |=> !comparatorIrqFlagQ) // R12
    else $error("software clear of flag lost");
  set_beats_clear_a: assert property (
    wrEn && paddr == ADDR_IRQ_FLG && cmp.mismatch
    |=> comparatorIrqFlagQ) // R16
    else $error("clear beat a persisting mismatch");
  irq_gated_a: assert property (irqReq |-> $past(comparatorIrqFlagQ) &&
    $past(intCtlQ[BIT_GLOBAL_GATE]) && $past(gatesOpen)) // R13
    else $error("request without all enables");
  off_mode_a: assert property (
    cmpCtlQ[2:0] == CRI_MODE_OFF |=> !cmpPowerOn) // R6
    else $error("comparator on in off mode");
  high_tap_a: assert property (!vrefCtlQ[BIT_REF_RANGE] |=>
    refTapNumer == {1'b0, $past(vrefCtlQ[3:0])} + HIGH_RANGE_BASE) // R3
    else $error("high range tap wrong");
  low_tap_a: assert property (vrefCtlQ[BIT_REF_RANGE] |=>
    refTapNumer == {1'b0, $past(vrefCtlQ[3:0])}) // R2
    else $error("low range tap wrong");
  vref_reserved_a: assert property (
    pready && $past(paddr) == ADDR_VREF_CTL |-> !prdata[6] && !prdata[4]) // R10
    else $error("reserved reference bits read nonzero");
  result_ro_a: assert property (
    wrEn && paddr == ADDR_CMP_CTL |=> !cmpCtlQ[BIT_RESULT]) // R19
    else $error("result bit became writable");

  flag_cov: cover property (cmp.mismatch ##1 comparatorIrqFlagQ);
  irq_cov:  cover property (irqReq);
  wake_cov: cover property (wakeReq);
  err_cov:  cover property (pslverr && pready);
endmodule

// ### tb/comparator_reference_and_interrupt_test.sv
/*
  Self-checking bench for the comparator reference and interrupt block.
  Assumes an APB slave with one wait state and the far-side model.
*/
`timescale 1ns/1ns
module comparator_reference_and_interrupt_test
  import cri_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic        err;
  } cri_row_t;
  logic        core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cmpRaw, sleepActive, refEnable, refRangeSelect, refRouted;
  logic        inputSwitch, cmpPowerOn, irqReq, wakeReq, er;
  logic [3:0]  refLevelCode;
  logic [4:0]  refTapNumer;
  logic [2:0]  comparatorModeCode;
  logic [5:0]  pinDirection;
  logic [6:0]  vinNum;
  int          n_mismatch, num_checks;
  cri_row_t    rows [6];

  cri_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpRaw(cmpRaw),
    .sleepActive(sleepActive), .refEnable(refEnable),
    .refRangeSelect(refRangeSelect), .refLevelCode(refLevelCode),
    .refTapNumer(refTapNumer), .refRouted(refRouted),
    .comparatorModeCode(comparatorModeCode), .inputSwitch(inputSwitch),
    .cmpPowerOn(cmpPowerOn), .pinDirection(pinDirection),
    .irqReq(irqReq), .wakeReq(wakeReq));
  cri_cmp_model far_u (.core_clk(core_clk), .arst_n(arst_n),
    .refEnable(refEnable), .refRangeSelect(refRangeSelect),
    .refTapNumer(refTapNumer), .refRouted(refRouted),
    .cmpPowerOn(cmpPowerOn), .vinNum(vinNum), .cmpRaw(cmpRaw));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // report and compare tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chkReg(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkPin(string n, logic [5:0] e, logic [5:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // ---------------------------------------------------------------
  // APB master: hold request until pready sampled high
  // ---------------------------------------------------------------
  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0000_00, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // look mid-cycle, where pready stands settled before its edge
    for (i = 0; i < 20; i++) begin
      @(negedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end
  endtask
  task automatic rdChk(string n, logic [11:0] a, logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chkReg(n, {24'h0000_00, e}, rd);
  endtask

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sleepActive = 1'b0;
    vinNum = 7'h00;
    rows[0] = {1'b0, ADDR_VREF_CTL, 8'h00, 8'h00, 1'b0};
    rows[1] = {1'b0, ADDR_CMP_CTL, 8'h00, 8'h00, 1'b0};
    rows[2] = {1'b0, ADDR_PIN_DIR, 8'h00, 8'h3f, 1'b0};
    rows[3] = {1'b1, ADDR_VREF_CTL, 8'hff, 8'haf, 1'b0};
    rows[4] = {1'b1, ADDR_IRQ_ENA, 8'hff, 8'hc9, 1'b0};
    rows[5] = {1'b0, 12'h000, 8'h00, 8'h00, 1'b1};
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    // reset values, masks, unmapped place
    foreach (rows[k]) begin
      if (rows[k].wr) apb(1'b1, rows[k].a, rows[k].d);
      apb(1'b0, rows[k].a, 8'h00);
      chkReg("row read", {24'h0000_00, rows[k].e}, rd);
      chkPin("row error", {5'h00, rows[k].err}, {5'h00, er});
    end
    $display("test register table done");
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, ADDR_VREF_CTL, {2'b10, c[4], 1'b0, c[3:0]});
      repeat (2) @(posedge core_clk);
      chkPin("tap", c[4] ? {2'b00, c[3:0]} : {2'b00, c[3:0]} + 6'h08,
             {1'b0, refTapNumer});
      chkPin("range", {5'h00, c[4]}, {5'h00, refRangeSelect});
      chkPin("code", {2'b00, c[3:0]}, {2'b00, refLevelCode});
    end
    $display("test ladder done");
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, ADDR_CMP_CTL, {5'h00, m[2:0]});
      repeat (2) @(posedge core_clk);
      chkPin("routed", {5'h00, REF_MODE_MASK[m]}, {5'h00, refRouted});
      chkPin("power", {5'h00, m != 0 && m != 7}, {5'h00, cmpPowerOn});
    end
    apb(1'b1, ADDR_VREF_CTL, 8'h00);
    repeat (2) @(posedge core_clk);
    chkPin("ref off", 6'h00, {5'h00, refEnable});
    $display("test modes done");
    apb(1'b1, ADDR_VREF_CTL, 8'h80);
    apb(1'b1, ADDR_CMP_CTL, 8'h03);
    repeat (4) @(posedge core_clk);
    rdChk("cmp low", ADDR_CMP_CTL, 8'h03);
    apb(1'b1, ADDR_IRQ_FLG, 8'h00);
    rdChk("flag clear", ADDR_IRQ_FLG, 8'h00);
    vinNum <= 7'h3c;
    repeat (6) @(posedge core_clk);
    rdChk("flag rise", ADDR_IRQ_FLG, 8'h08);
    chkPin("irq gated", 6'h00, {5'h00, irqReq});
    rdChk("cmp high", ADDR_CMP_CTL, 8'h43);
    apb(1'b1, ADDR_IRQ_FLG, 8'h00);
    rdChk("flag ack", ADDR_IRQ_FLG, 8'h00);
    vinNum <= 7'h00;
    repeat (6) @(posedge core_clk);
    apb(1'b1, ADDR_IRQ_FLG, 8'h00);
    repeat (2) @(posedge core_clk);
    rdChk("flag sticky", ADDR_IRQ_FLG, 8'h08);
    rdChk("cmp fall", ADDR_CMP_CTL, 8'h03);
    apb(1'b1, ADDR_IRQ_FLG, 8'h00);
    rdChk("flag ack2", ADDR_IRQ_FLG, 8'h00);
    apb(1'b1, ADDR_IRQ_FLG, 8'h08);
    rdChk("flag soft", ADDR_IRQ_FLG, 8'h08);
    apb(1'b1, ADDR_INT_CTL, 8'hc0);
    apb(1'b1, ADDR_IRQ_ENA, 8'h08);
    repeat (3) @(posedge core_clk);
    chkPin("irq on", 6'h01, {5'h00, irqReq});
    $display("test interrupt done");
    sleepActive <= 1'b1;
    repeat (3) @(posedge core_clk);
    chkPin("wake", 6'h01, {5'h00, wakeReq});
    chkPin("ref sleep", 6'h01, {5'h00, refEnable});
    sleepActive <= 1'b0;
    rdChk("vref kept", ADDR_VREF_CTL, 8'h80);
    rdChk("cmp kept", ADDR_CMP_CTL, 8'h03);
    $display("test sleep done");
    apb(1'b1, ADDR_CMP_CTL, 8'h43);
    rdChk("result ro", ADDR_CMP_CTL, 8'h03);
    apb(1'b1, ADDR_CMP_CTL, 8'h13);
    repeat (2) @(posedge core_clk);
    rdChk("invert", ADDR_CMP_CTL, 8'h53);
    apb(1'b1, ADDR_CMP_CTL, 8'h0b);
    repeat (1) @(posedge core_clk);
    chkPin("input sw", 6'h01, {5'h00, inputSwitch});
    $display("test polarity done");
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chkPin("rst ref", 6'h00, {5'h00, refEnable});
    chkPin("rst mode", 6'h00, {3'h0, comparatorModeCode});
    chkPin("rst dir", 6'h3f, pinDirection);
    arst_n <= 1'b1;
    rdChk("rst flag", ADDR_IRQ_FLG, 8'h00);
    $display("test reset done");
    conclude();
  end
endmodule

// ### tb/cri_cmp_model.sv
/*
  Behavioural comparator and resistor ladder on the far side of the
  reference and comparator control outputs.
  Assumes vinNum is the external input level in 96ths of the supply.
*/
`timescale 1ns/1ns
module cri_cmp_model
  import cri_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       refEnable,
  input  wire logic       refRangeSelect,
  input  wire logic [4:0] refTapNumer,
  input  wire logic       refRouted,
  input  wire logic       cmpPowerOn,
  input  wire logic [6:0] vinNum,
  output      logic       cmpRaw
);
  logic [7:0] refLevel;
  // ---------------------------------------------------------------
  // ladder: low range tap/24, high range tap/32, in 96ths
  // ---------------------------------------------------------------
  always_comb begin
    refLevel = 8'h00;
    if (refEnable) begin
      if (refRangeSelect) begin
        refLevel = {1'b0, refTapNumer, 2'b00};
      end else begin
        refLevel = {3'b000, refTapNumer} * 8'h03;
      end
    end
  end
  // ---------------------------------------------------------------
  // comparator: mid supply on the pin when reference not routed
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmpRaw <= 1'b0;
    end else if (!cmpPowerOn) begin
      cmpRaw <= 1'b0;
    end else if (refRouted) begin
      cmpRaw <= ({1'b0, vinNum} > refLevel);
    end else begin
      cmpRaw <= (vinNum > 7'h30);
    end
  end
endmodule
